/* fps_pkg.sv */
// Constants and types of the flyback protection sequencer
// How it works
// RULE1 - At start-up, wait for protect low level
// RULE2 - Charge soft-start, then begin switching
// RULE3 - Any protection stops switching; restart or latch
// RULE4 - Restart: drop to lockout, recharge, resume
// RULE5 - Latched: power-down at once, clamp enabled
// RULE6 - Lockout outside start-up stops and latches
// RULE7 - Four overvoltage cycles latch; drop clears count
// RULE8 - Protect high or low four strokes latches
// RULE9 - On-period capped at 80 percent
// RULE10 - Eight max-duty strokes trigger restart
// RULE11 - Overload timer runs above 400 mV level
// RULE12 - Overload beyond 60 ms latches off
// RULE13 - High-power mode fixed 65 kHz
// RULE14 - Peak mode raises frequency and current
// RULE15 - Medium mode 27.5 kHz, reduced current
// RULE16 - Low mode lower frequency, 25 percent current
// RULE17 - Current reaching control level ends pulse
// RULE18 - Blanking hides early current comparisons
// RULE19 - Jitter spreads switching frequency
// RULE20 - Only power-down reset clears latch; power-down also clears counters
// RULE21 - Mode chosen per cycle with hysteresis
package fps_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned LVL_W = 8;
  localparam logic [LVL_W-1:0] LVL_OVERLOAD = 8'h66;
  localparam logic [LVL_W-1:0] LVL_PEAK_UP = 8'hC0;
  localparam logic [LVL_W-1:0] LVL_PEAK_DN = 8'hB0;
  localparam logic [LVL_W-1:0] LVL_MED_UP = 8'h50;
  localparam logic [LVL_W-1:0] LVL_MED_DN = 8'h48;
  localparam logic [LVL_W-1:0] LVL_LOW_UP = 8'h30;
  localparam logic [LVL_W-1:0] LVL_LOW_DN = 8'h28;
  localparam logic [LVL_W-1:0] LVL_PEAK_FLOOR = 8'hC0;
  localparam logic [LVL_W-1:0] LVL_LOW_FIXED = 8'h40;
  localparam int unsigned PER_W = 12;
  localparam int unsigned HIGH_HZ = 65000;
  localparam int unsigned PEAK_HZ = 100000;
  localparam int unsigned MED_HZ = 27500;
  localparam int unsigned LOW_HZ = 15000;
  localparam logic [PER_W-1:0] PER_HIGH = PER_W'(CLK_HZ / HIGH_HZ);
  localparam logic [PER_W-1:0] PER_PEAK = PER_W'(CLK_HZ / PEAK_HZ);
  localparam logic [PER_W-1:0] PER_MED = PER_W'(CLK_HZ / MED_HZ);
  localparam logic [PER_W-1:0] PER_LOW = PER_W'(CLK_HZ / LOW_HZ);
  localparam int unsigned DUTY_MAX_PCT = 80;
  localparam int unsigned BLANK_NS = 300;
  localparam logic [PER_W-1:0] BLANK_CYC = PER_W'((BLANK_NS * 40 + 999) / 1000);
  localparam int unsigned OVP_COUNT = 4;
  localparam int unsigned PROT_COUNT = 4;
  localparam int unsigned DUTY_COUNT = 8;
  localparam int unsigned OVL_MS = 60;
  localparam int unsigned OVL_CYC = (CLK_HZ / 1000) * OVL_MS;
  localparam int unsigned OVL_W = 22;
  localparam int unsigned SOFT_CYC = 64;
  localparam logic [3:0] JIT_SEED = 4'h9;
  typedef enum logic [1:0] {FPS_PEAK, FPS_HIGH, FPS_MED, FPS_LOW} fps_mode_t;
  typedef enum logic [2:0] {FPS_OFF, FPS_WAIT_PROT, FPS_SOFT, FPS_RUN, FPS_RESTART,
    FPS_LATCHED} fps_state_t;
endpackage : fps_pkg

/* fps_stroke.sv */
// Switching-period and gate pulse generator with blanking and duty cap
module fps_stroke
  import fps_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Control
  input wire logic enable,
  input wire logic [PER_W-1:0] period,
  input wire logic cs_trip,
  // Status
  output logic gate,
  output logic stroke_end,
  output logic duty_limited
);
  logic [PER_W-1:0] cnt_reg, cnt_next;
  logic gate_reg, gate_next;
  logic end_reg, end_next;
  logic lim_reg, lim_next;
  logic [PER_W-1:0] on_max;

  always_comb begin
    on_max = PER_W'((32'(period) * DUTY_MAX_PCT) / 100);
    cnt_next = cnt_reg;
    gate_next = gate_reg;
    end_next = 1'b0;
    lim_next = lim_reg;
    if (!enable) begin
      cnt_next = '0;
      gate_next = 1'b0;
      lim_next = 1'b0;
    end else if (cnt_reg >= period - 12'h001) begin
      cnt_next = '0;
      gate_next = 1'b1;
      end_next = 1'b1;
    end else begin
      cnt_next = cnt_reg + 12'h001;
      // The flag of the ended stroke must stand while stroke_end is high
      if (end_reg) lim_next = 1'b0;
      if (gate_reg && cnt_reg + 12'h001 >= on_max) begin // RULE9
        gate_next = 1'b0;
        lim_next = 1'b1;
      end else if (gate_reg && cs_trip && cnt_reg >= BLANK_CYC) begin // RULE17 RULE18
        gate_next = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt_reg <= '0;
      gate_reg <= 1'b0;
      end_reg <= 1'b0;
      lim_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      gate_reg <= gate_next;
      end_reg <= end_next;
      lim_reg <= lim_next;
    end
  end

  assign gate = gate_reg;
  assign stroke_end = end_reg;
  assign duty_limited = lim_reg;

  a_duty_cap: assert property (@(posedge clk) disable iff (!rst_b) // RULE9
    gate_reg |-> cnt_reg < on_max) else $error("duty cap exceeded");
  a_blank_hold: assert property (@(posedge clk) disable iff (!rst_b) // RULE18
    (enable && gate_reg && cnt_reg < BLANK_CYC && cnt_reg + 12'h001 < on_max
    && cnt_reg < period - 12'h001) |=> gate_reg) else $error("gate ended in blanking");
endmodule : fps_stroke

/* fps_sequencer.sv */
// Flyback start-up, protection and power-mode sequencer
module fps_sequencer
  import fps_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Comparator inputs
  input wire logic supply_startup,
  input wire logic supply_low_lockout,
  input wire logic supply_over_threshold,
  input wire logic protect_low,
  input wire logic protect_high,
  input wire logic primary_current_input,
  input wire logic [LVL_W-1:0] peak_current_control_level,
  input wire logic soft_start_done,
  // Outputs
  output logic gate_drive,
  output logic driver_enable,
  output logic soft_start_charge,
  output logic supply_clamp,
  output logic overload_trip,
  output logic latched_off,
  output logic [1:0] power_mode,
  output logic [LVL_W-1:0] peak_limit
);
  // Comparators are asynchronous to clk, so two stages first
  logic [5:0] s1_reg, s2_reg;
  logic [LVL_W-1:0] lv1_reg, lva_reg, lvb_reg, lv2_reg;
  logic st_s, uv_s, ov_s, pl_s, ph_s, cs_s, ss_s;
  assign {st_s, uv_s, ov_s, pl_s, ph_s, ss_s} = s2_reg;
  logic cs1_reg, cs2_reg;
  assign cs_s = cs2_reg;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s1_reg <= '0;
      s2_reg <= '0;
      lv1_reg <= '0;
      lva_reg <= '0;
      lvb_reg <= '0;
      lv2_reg <= '0;
      cs1_reg <= 1'b0;
      cs2_reg <= 1'b0;
    end else begin
      s1_reg <= {supply_startup, supply_low_lockout, supply_over_threshold, protect_low,
        protect_high, soft_start_done};
      s2_reg <= s1_reg;
      lv1_reg <= peak_current_control_level;
      lva_reg <= lv1_reg;
      lvb_reg <= lva_reg;
      // A word may be caught mid-change, so it is taken once two samples agree
      if (lva_reg == lvb_reg) lv2_reg <= lva_reg;
      cs1_reg <= primary_current_input;
      cs2_reg <= cs1_reg;
    end
  end

  fps_state_t st_reg, st_next;
  fps_mode_t mode_reg, mode_next;
  logic [2:0] ovp_reg, ovp_next;
  logic [2:0] prot_reg, prot_next;
  logic [3:0] duty_reg, duty_next;
  logic [OVL_W-1:0] ovl_reg, ovl_next;
  logic [6:0] soft_reg, soft_next;
  logic [3:0] jit_reg, jit_next;
  logic trip_reg, trip_next;
  logic gate_reg, drv_reg, chg_reg, clamp_reg, latch_reg;
  logic [LVL_W-1:0] lim_reg, lim_next;
  logic [PER_W-1:0] period;
  logic stroke_gate, stroke_end, duty_lim, running;
  logic latch_ev, restart_ev;

  assign running = (st_reg == FPS_RUN);

  fps_stroke u_stroke (
    .clk(clk),
    .rst_b(rst_b),
    .enable(running),
    .period(period),
    .cs_trip(cs_s),
    .gate(stroke_gate),
    .stroke_end(stroke_end),
    .duty_limited(duty_lim)
  );

  always_comb begin
    unique case (mode_reg)
      FPS_PEAK: period = PER_PEAK; // RULE14
      FPS_HIGH: period = PER_HIGH; // RULE13
      FPS_MED: period = PER_MED; // RULE15
      FPS_LOW: period = PER_LOW; // RULE16
    endcase
    period = period + PER_W'(jit_reg); // RULE19
  end

  // Fault counters and mode selection, updated once per stroke; overload timer updated every clock
  always_comb begin
    ovp_next = ovp_reg;
    prot_next = prot_reg;
    duty_next = duty_reg;
    ovl_next = ovl_reg;
    mode_next = mode_reg;
    jit_next = jit_reg;
    lim_next = lim_reg;
    trip_next = trip_reg;
    if (running && stroke_end) begin
      ovp_next = ov_s ? ovp_reg + 3'h1 : 3'h0; // RULE7
      prot_next = (pl_s || ph_s) ? prot_reg + 3'h1 : 3'h0; // RULE8
      duty_next = duty_lim ? duty_reg + 4'h1 : 4'h0; // RULE10
      jit_next = {jit_reg[2:0], jit_reg[3] ^ jit_reg[2]};
      unique case (mode_reg) // RULE21
        FPS_PEAK: mode_next = (lv2_reg < LVL_PEAK_DN) ? FPS_HIGH : FPS_PEAK;
        FPS_HIGH: mode_next = (lv2_reg > LVL_PEAK_UP) ? FPS_PEAK :
          (lv2_reg < LVL_MED_DN) ? FPS_MED : FPS_HIGH;
        FPS_MED: mode_next = (lv2_reg > LVL_MED_UP) ? FPS_HIGH :
          (lv2_reg < LVL_LOW_DN) ? FPS_LOW : FPS_MED;
        FPS_LOW: mode_next = (lv2_reg > LVL_LOW_UP) ? FPS_MED : FPS_LOW;
      endcase
      unique case (mode_next)
        FPS_PEAK: lim_next = (lv2_reg > LVL_PEAK_FLOOR) ? lv2_reg : LVL_PEAK_FLOOR; // RULE14
        FPS_LOW: lim_next = LVL_LOW_FIXED; // RULE16
        default: lim_next = lv2_reg; // RULE15 RULE17
      endcase
    end
    if (running && lv2_reg > LVL_OVERLOAD) begin // RULE11
      if (ovl_reg < OVL_W'(OVL_CYC)) ovl_next = ovl_reg + 22'h000001;
    end else begin
      ovl_next = '0;
    end
    if (running && ovl_reg >= OVL_W'(OVL_CYC)) trip_next = 1'b1; // RULE12
    if (st_reg == FPS_OFF) begin // RULE20
      ovp_next = '0;
      prot_next = '0;
      duty_next = '0;
      ovl_next = '0;
      trip_next = 1'b0;
    end
  end

  assign latch_ev = (ovp_reg >= 3'(OVP_COUNT)) || (prot_reg >= 3'(PROT_COUNT)) || trip_reg
    || uv_s; // RULE7 RULE8 RULE12 RULE6
  assign restart_ev = (duty_reg >= 4'(DUTY_COUNT)); // RULE10

  // Sequencer; reset of the latch needs a full supply collapse on rst_b
  always_comb begin
    st_next = st_reg;
    soft_next = soft_reg;
    unique case (st_reg)
      FPS_OFF: if (st_s) st_next = FPS_WAIT_PROT; // RULE4
      FPS_WAIT_PROT: begin
        if (pl_s) st_next = FPS_SOFT; // RULE1
        soft_next = '0;
      end
      FPS_SOFT: begin
        soft_next = soft_reg + 7'h01;
        if (ss_s || soft_reg >= 7'(SOFT_CYC)) st_next = FPS_RUN; // RULE2
      end
      FPS_RUN: begin
        if (latch_ev) st_next = FPS_LATCHED; // RULE3 RULE5 RULE6
        else if (restart_ev) st_next = FPS_RESTART; // RULE3 RULE4
      end
      FPS_RESTART: if (uv_s) st_next = FPS_OFF; // RULE4
      FPS_LATCHED: st_next = FPS_LATCHED; // RULE20
      default: st_next = FPS_LATCHED;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_reg <= FPS_OFF;
      mode_reg <= FPS_HIGH;
      ovp_reg <= '0;
      prot_reg <= '0;
      duty_reg <= '0;
      ovl_reg <= '0;
      soft_reg <= '0;
      jit_reg <= JIT_SEED;
      lim_reg <= '0;
      trip_reg <= 1'b0;
      gate_reg <= 1'b0;
      drv_reg <= 1'b0;
      chg_reg <= 1'b0;
      clamp_reg <= 1'b0;
      latch_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      mode_reg <= mode_next;
      ovp_reg <= ovp_next;
      prot_reg <= prot_next;
      duty_reg <= duty_next;
      ovl_reg <= ovl_next;
      soft_reg <= soft_next;
      jit_reg <= jit_next;
      lim_reg <= lim_next;
      trip_reg <= trip_next;
      gate_reg <= stroke_gate && running && !latch_ev && !restart_ev; // RULE3
      drv_reg <= (st_next == FPS_RUN);
      chg_reg <= (st_next == FPS_SOFT); // RULE2
      clamp_reg <= (st_next == FPS_LATCHED); // RULE5
      latch_reg <= (st_next == FPS_LATCHED);
    end
  end

  assign gate_drive = gate_reg;
  assign driver_enable = drv_reg;
  assign soft_start_charge = chg_reg;
  assign supply_clamp = clamp_reg;
  assign overload_trip = trip_reg;
  assign latched_off = latch_reg;
  assign power_mode = mode_reg;
  assign peak_limit = lim_reg;

  a_wait_protect: assert property (@(posedge clk) disable iff (!rst_b) // RULE1
    (st_reg == FPS_WAIT_PROT && !pl_s) |=> st_reg != FPS_SOFT) else $error("left wait early");
  a_soft_first: assert property (@(posedge clk) disable iff (!rst_b) // RULE2
    $rose(driver_enable) |-> $past(soft_start_charge)) else $error("no soft start");
  a_gate_run: assert property (@(posedge clk) disable iff (!rst_b) // RULE3
    gate_drive |-> $past(running)) else $error("gate outside run");
  a_latch_stops: assert property (@(posedge clk) disable iff (!rst_b) // RULE5
    (running && latch_ev) |=> ##1 (latched_off && supply_clamp && !gate_drive))
    else $error("latch not entered");
  a_lockout_latch: assert property (@(posedge clk) disable iff (!rst_b) // RULE6
    (running && uv_s) |=> (latched_off && !driver_enable)) else $error("lockout no latch");
  a_ovp_count: assert property (@(posedge clk) disable iff (!rst_b) // RULE7
    (running && stroke_end && !ov_s) |=> ovp_reg == 3'h0) else $error("ovp not cleared");
  a_ovp_latch: assert property (@(posedge clk) disable iff (!rst_b) // RULE7
    (running && ovp_reg == 3'h4) |=> st_reg == FPS_LATCHED) else $error("overvoltage no latch");
  a_prot_latch: assert property (@(posedge clk) disable iff (!rst_b) // RULE8
    (running && prot_reg == 3'h4) |=> st_reg == FPS_LATCHED) else $error("protect no latch");
  a_duty_restart: assert property (@(posedge clk) disable iff (!rst_b) // RULE10
    (running && !latch_ev && duty_reg == 4'h8) |=> st_reg == FPS_RESTART)
    else $error("no restart");
  a_restart_off: assert property (@(posedge clk) disable iff (!rst_b) // RULE4
    (st_reg == FPS_RESTART && uv_s) |=> st_reg == FPS_OFF) else $error("restart stuck");
  a_timer_reset: assert property (@(posedge clk) disable iff (!rst_b) // RULE11
    (running && lv2_reg <= LVL_OVERLOAD) |=> ovl_reg == '0) else $error("timer not cleared");
  a_timer_count: assert property (@(posedge clk) disable iff (!rst_b) // RULE11
    (running && lv2_reg > LVL_OVERLOAD && ovl_reg < OVL_W'(OVL_CYC))
    |=> ovl_reg == $past(ovl_reg) + 22'h000001) else $error("timer not counting");
  a_timer_trip: assert property (@(posedge clk) disable iff (!rst_b) // RULE12
    (running && ovl_reg >= OVL_W'(OVL_CYC)) |=> overload_trip) else $error("no overload trip");
  a_latch_hold: assert property (@(posedge clk) disable iff (!rst_b) // RULE20
    latched_off |=> latched_off) else $error("latch released");
  a_counters_clear: assert property (@(posedge clk) disable iff (!rst_b) // RULE20
    (st_reg == FPS_OFF) |=> (ovp_reg == 3'h0 && prot_reg == 3'h0 && duty_reg == 4'h0
    && ovl_reg == '0 && !overload_trip)) else $error("counters not cleared");
  a_low_limit: assert property (@(posedge clk) disable iff (!rst_b) // RULE16
    (mode_reg == FPS_LOW && st_reg == FPS_RUN && $past(running && stroke_end))
    |-> peak_limit == LVL_LOW_FIXED) else $error("low mode limit");
  a_peak_floor: assert property (@(posedge clk) disable iff (!rst_b) // RULE14
    (mode_reg == FPS_PEAK && st_reg == FPS_RUN && $past(running && stroke_end))
    |-> peak_limit >= LVL_PEAK_FLOOR) else $error("peak mode limit");
  a_restart_gate: assert property (@(posedge clk) disable iff (!rst_b) // RULE4
    (st_reg == FPS_RESTART) |-> ##1 !gate_drive) else $error("switching in restart");
  c_start: cover property (@(posedge clk) disable iff (!rst_b) $rose(driver_enable));
  c_latch: cover property (@(posedge clk) disable iff (!rst_b) $rose(latched_off));
  c_restart: cover property (@(posedge clk) disable iff (!rst_b) st_reg == FPS_RESTART);
  c_low: cover property (@(posedge clk) disable iff (!rst_b) mode_reg == FPS_LOW);
  c_peak: cover property (@(posedge clk) disable iff (!rst_b) mode_reg == FPS_PEAK);
endmodule : fps_sequencer

/* fps_stage_model.sv */
// Behavioural power stage and comparators facing the sequencer
module fps_stage_model (
  // Clock
  input wire logic clk,
  // From the sequencer
  input wire logic gate_drive,
  input wire logic soft_start_charge,
  // Stage setting, cycles of on-time until the current trips
  input wire logic [11:0] ramp_len,
  // To the sequencer
  output logic primary_current_input,
  output logic soft_start_done
);
  timeunit 1ns;
  timeprecision 1ps;
  int on_cnt = 0;
  int chg_cnt = 0;
  initial begin
    primary_current_input = 1'b0;
    soft_start_done = 1'b0;
  end
  // Current ramps only while the switch conducts; a huge ramp never trips
  always @(negedge clk) begin
    on_cnt = (gate_drive === 1'b1) ? on_cnt + 1 : 0;
    primary_current_input <= (on_cnt >= int'(ramp_len));
    chg_cnt = (soft_start_charge === 1'b1) ? chg_cnt + 1 : 0;
    soft_start_done <= (chg_cnt >= 20);
  end
endmodule : fps_stage_model

/* fps_sequencer_bench.sv */
// Self-checking bench of the flyback protection sequencer
module fps_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import fps_pkg::*;
  logic clk;
  logic rst_b;
  logic supply_startup;
  logic supply_low_lockout;
  logic supply_over_threshold;
  logic protect_low;
  logic protect_high;
  logic [LVL_W-1:0] level;
  logic [11:0] ramp_len;
  logic primary_current_input;
  logic soft_start_done;
  logic gate_drive;
  logic driver_enable;
  logic soft_start_charge;
  logic supply_clamp;
  logic overload_trip;
  logic latched_off;
  logic [1:0] power_mode;
  logic [LVL_W-1:0] peak_limit;
  int errors = 0;
  int n_checks = 0;
  int cycles = 0;
  localparam int W_CHG = 0;
  localparam int W_DRV = 1;
  localparam int W_LATCH = 2;

  fps_sequencer i_dut (.clk(clk), .rst_b(rst_b), .supply_startup(supply_startup),
    .supply_low_lockout(supply_low_lockout), .supply_over_threshold(supply_over_threshold),
    .protect_low(protect_low), .protect_high(protect_high),
    .primary_current_input(primary_current_input), .peak_current_control_level(level),
    .soft_start_done(soft_start_done), .gate_drive(gate_drive), .driver_enable(driver_enable),
    .soft_start_charge(soft_start_charge), .supply_clamp(supply_clamp),
    .overload_trip(overload_trip), .latched_off(latched_off), .power_mode(power_mode),
    .peak_limit(peak_limit));
  fps_stage_model i_stage (.clk(clk), .gate_drive(gate_drive),
    .soft_start_charge(soft_start_charge), .ramp_len(ramp_len),
    .primary_current_input(primary_current_input), .soft_start_done(soft_start_done));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  // Picks the output that wait_for watches, so no reference argument is needed
  function automatic logic watched(input int sel);
    if (sel == W_CHG) return soft_start_charge;
    if (sel == W_DRV) return driver_enable;
    return latched_off;
  endfunction : watched

  task automatic wait_for(input int sel, input logic v, input int lim);
    for (int i = 0; i < lim && watched(sel) !== v; i++) @(negedge clk);
  endtask : wait_for

  // Returns cycles until the next gate rise, so a call just after a rise gives the period
  task automatic next_rise(output int t);
    t = 0;
    while (gate_drive !== 1'b0 && t < 4000) begin
      @(negedge clk);
      t++;
    end
    while (gate_drive !== 1'b1 && t < 4000) begin
      @(negedge clk);
      t++;
    end
  endtask : next_rise

  task automatic bring_up;
    supply_startup = 1'b0;
    supply_low_lockout = 1'b0;
    supply_over_threshold = 1'b0;
    protect_low = 1'b0;
    protect_high = 1'b0;
    level = 8'h80;
    ramp_len = 12'h064;
    rst_b = 1'b0;
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    check("latched_off", 0, latched_off);
    check("power_mode", 1, power_mode);
    supply_startup = 1'b1;
    repeat (40) @(negedge clk);
    check("soft_start_charge", 0, soft_start_charge);
    protect_low = 1'b1;
    wait_for(W_CHG, 1'b1, 12);
    check("soft_start_charge", 1, soft_start_charge);
    check("gate_drive", 0, gate_drive);
    protect_low = 1'b0;
    wait_for(W_DRV, 1'b1, 100);
    check("driver_enable", 1, driver_enable);
  endtask : bring_up

  task automatic t_duty_restart;
    int t;
    int hi;
    bring_up();
    ramp_len = 12'hFFF;
    next_rise(t);
    hi = 0;
    while (gate_drive === 1'b1 && hi < 4000) begin
      @(negedge clk);
      hi++;
    end
    next_rise(t);
    check("duty cap", 1, hi > 0 && hi * 100 <= DUTY_MAX_PCT * (hi + t));
    wait_for(W_DRV, 1'b0, 6000);
    check("driver_enable", 0, driver_enable);
    check("latched_off", 0, latched_off);
    supply_startup = 1'b0;
    supply_low_lockout = 1'b1;
    repeat (10) @(negedge clk);
    supply_low_lockout = 1'b0;
    ramp_len = 12'h064;
    supply_startup = 1'b1;
    protect_low = 1'b1;
    wait_for(W_DRV, 1'b1, 200);
    protect_low = 1'b0;
    check("driver_enable", 1, driver_enable);
    $display("duty and restart test done");
  endtask : t_duty_restart

  task automatic t_supply_over;
    int t;
    bring_up();
    next_rise(t);
    // Bursts of two strokes must never add up to the trip count
    for (int i = 0; i < 2; i++) begin
      supply_over_threshold = 1'b1;
      repeat (2) next_rise(t);
      supply_over_threshold = 1'b0;
      repeat (2) next_rise(t);
    end
    check("latched_off", 0, latched_off);
    supply_over_threshold = 1'b1;
    wait_for(W_LATCH, 1'b1, 4000);
    check("latched_off", 1, latched_off);
    check("supply_clamp", 1, supply_clamp);
    check("driver_enable", 0, driver_enable);
    supply_over_threshold = 1'b0;
    protect_low = 1'b1;
    repeat (50) @(negedge clk);
    check("latched_off", 1, latched_off);
    check("gate_drive", 0, gate_drive);
    $display("overvoltage test done");
  endtask : t_supply_over

  task automatic t_protect;
    int t;
    for (int i = 0; i < 2; i++) begin
      bring_up();
      next_rise(t);
      protect_high = (i == 0);
      protect_low = (i == 1);
      repeat (2) next_rise(t);
      check("latched_off", 0, latched_off);
      wait_for(W_LATCH, 1'b1, 4000);
      check("latched_off", 1, latched_off);
    end
    bring_up();
    supply_low_lockout = 1'b1;
    wait_for(W_LATCH, 1'b1, 10);
    check("latched_off", 1, latched_off);
    check("driver_enable", 0, driver_enable);
    $display("protect and lockout test done");
  endtask : t_protect

  task automatic t_modes;
    int t;
    logic [7:0] lv[6] = '{8'h80, 8'h4C, 8'h40, 8'h10, 8'h80, 8'hF0};
    logic [1:0] md[6] = '{2'h1, 2'h1, 2'h2, 2'h3, 2'h1, 2'h0};
    int pr[4] = '{PER_PEAK, PER_HIGH, PER_MED, PER_LOW};
    int jit_seen = 0;
    int last_off = 0;
    bring_up();
    for (int i = 0; i < 6; i++) begin
      level = lv[i];
      repeat (3) next_rise(t);
      check("power_mode", md[i], power_mode);
      next_rise(t);
      check("period", 1, t >= pr[md[i]] - 1 && t <= pr[md[i]] + 16);
      // Spread spectrum: the offset from the nominal period must move
      if (i > 0 && t - pr[md[i]] != last_off) jit_seen++;
      last_off = t - pr[md[i]];
      if (md[i] == 2'h3) begin
        check("peak_limit", LVL_LOW_FIXED, peak_limit);
      end
      if (md[i] == 2'h0) begin
        check("peak floor", 1, peak_limit >= LVL_PEAK_FLOOR && t < PER_HIGH);
      end
    end
    check("jitter", 1, jit_seen > 0);
    // A short overload must not trip the timer
    check("overload_trip", 0, overload_trip);
    $display("power mode test done");
  endtask : t_modes

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict

  always @(posedge clk) begin
    cycles++;
    if (cycles == 95000) begin
      errors++;
      $display("timeout after %0d cycles", cycles);
      give_verdict();
    end
  end

  initial begin
    t_duty_restart();
    t_supply_over();
    t_protect();
    t_modes();
    give_verdict();
  end
endmodule : fps_sequencer_bench
